// [rtl/acp_defines.svh]
// Timing counts and command byte field positions of the converter command port.
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
`define ACP_CMD_BITS 8
`define ACP_START_BIT 7
`define ACP_KIND_BIT 6
`define ACP_OP_HI 5
`define ACP_OP_LO 4
`define ACP_RATE_HI 3
`define ACP_ADDR_HI 5
`define ACP_ADDR_LO 1
`define ACP_DIR_BIT 0
`define ACP_RESULT_DONE_BITS 23
`define ACP_RESULT_BITS 24
`define ACP_REG_MAX_BITS 24
`define ACP_SYS_CLK_NS 10
`define ACP_SCLK_PERIOD_NS 160
`define ACP_SCLK_HALF_CYC (`ACP_SCLK_PERIOD_NS / (2 * `ACP_SYS_CLK_NS))
`define ACP_RESULT_ADDR_RST 5'h06
`endif

// [rtl/acp_pkg.sv]
// Types and command byte builders shared by both ends of the command port.
`include "acp_defines.svh"
package acp_pkg;
   typedef enum logic [1:0] {
      OP_UNUSED = 2'b00,
      OP_POWERDOWN = 2'b01,
      OP_CALIBRATE = 2'b10,
      OP_SEQUENCE = 2'b11
   } acp_op_t;

   typedef enum logic [1:0] {
      PS_CONVERT = 2'b00,
      PS_SLEEP = 2'b01,
      PS_STANDBY = 2'b10,
      PS_RESERVED = 2'b11
   } acp_pstat_t;

   typedef enum logic [1:0] {
      DP_CMD = 2'b00,
      DP_WRITE = 2'b01,
      DP_READ = 2'b10,
      DP_IGNORE = 2'b11
   } acp_dphase_t;

   typedef enum logic [2:0] {
      HP_IDLE = 3'b000,
      HP_LOW = 3'b001,
      HP_HIGH = 3'b010,
      HP_END = 3'b011,
      HP_GAP = 3'b100
   } acp_hphase_t;

   // Conversion-type command byte: start bit set, kind bit clear.
   function automatic logic [7:0] acp_conv_cmd(input logic [1:0] op, input logic [3:0] rate);
      acp_conv_cmd = {1'b1, 1'b0, op, rate};
   endfunction : acp_conv_cmd

   // Register-access command byte: start and kind bits set, address, direction.
   function automatic logic [7:0] acp_reg_cmd(input logic [4:0] addr, input logic rd);
      acp_reg_cmd = {1'b1, 1'b1, addr, rd};
   endfunction : acp_reg_cmd
endpackage : acp_pkg

// [rtl/acp_if.sv]
// Serial pins between the converter command port and its host.
`timescale 1ns/1ps
`default_nettype none
interface acp_if;
   logic select_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   logic result_ready_n;

   modport device (
      input select_n,
      input sclk,
      input mosi,
      output miso,
      output miso_oe_n,
      output result_ready_n
   );

   modport host (
      output select_n,
      output sclk,
      output mosi,
      input miso,
      input miso_oe_n,
      input result_ready_n
   );
endinterface : acp_if
`default_nettype wire

// [rtl/acp_device.sv]
// Device end of the converter serial command port: command decode and register access.
`timescale 1ns/1ps
`default_nettype none
`include "acp_defines.svh"
// Overview of operation
// - Write bytes commit MSB first, each eighth clock.
// - No update before sixteen clocks.
// - Cut writes update only completed upper bytes.
// - Read mode lasts while select stays low.
// - Select release ends transfer, resets controller.
// - Data input ignored during reads.
// - Result read of 23 bits releases ready.
// - Host repeats short result read fully later.
// - Command start bit one; kind bit selects.
// - Host holds select across whole access.
// - Conversion command: operation and rate fields.
// - Register command: address and direction bit.
// - Operation decode: powerdown, calibrate, sequencer.
// - Host exits sequencer via powerdown, polls status.
// - Sequencer ends in sleep unless continuous.
// - Host mode change: exit, reprogram, start, poll.
// - Read data launched on falling clock edges.
// - Deselected: pins ignored, output released.
// - Ready low when result available.
module acp_device #(
   parameter logic [4:0] RESULT_ADDR = `ACP_RESULT_ADDR_RST
) (
   input wire logic sys_clk,
   input wire logic reset,
   acp_if.device bus,
   output logic [4:0] reg_addr,
   input wire logic [1:0] reg_bytes,
   input wire logic [23:0] reg_rd_data,
   output logic reg_wr_valid,
   output logic [1:0] reg_wr_index,
   output logic [7:0] reg_wr_byte,
   output logic cmd_valid,
   output logic [1:0] cmd_operation,
   output logic [3:0] cmd_rate,
   output logic calibration_start,
   input wire logic [1:0] calibration_select,
   output logic [1:0] calibration_kind,
   input wire logic [1:0] powerdown_target,
   input wire logic [1:0] sequencer_mode_select,
   input wire logic single_cycle_enable,
   input wire logic continuous_single_cycle,
   input wire logic result_update,
   input wire logic sequence_done,
   output logic [1:0] power_status
);

   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic ck_m;
      logic ck_s;
      logic ck_p;
      logic di_m;
      logic di_s;
      acp_pkg::acp_dphase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic [1:0] done_cnt;
      logic load;
      logic [23:0] tx;
      logic [4:0] out_cnt;
      logic miso;
      logic [4:0] addr;
      logic wr_valid;
      logic [1:0] wr_idx;
      logic [7:0] wr_byte;
      logic cmd_valid;
      logic [1:0] cmd_op;
      logic [3:0] cmd_rate;
      logic ready_n;
      acp_pkg::acp_pstat_t pstat;
   } acp_dev_state_t;

   acp_dev_state_t q;
   acp_dev_state_t d;
   logic rise;
   logic fall;
   logic [7:0] cmd_byte;
   logic result_clear;
   logic continuous;

   // Left-justifies a register value so its top bit leaves first whatever its width.
   function automatic logic [23:0] acp_align(input logic [23:0] data, input logic [1:0] bytes);
      unique case (bytes)
         2'h1: acp_align = {data[7:0], 16'h0000};
         2'h2: acp_align = {data[15:0], 8'h00};
         default: acp_align = data;
      endcase
   endfunction : acp_align

   // Edges come from the synchronised clock copy and its one-cycle delayed copy.
   assign rise = q.ck_s & ~q.ck_p;
   assign fall = ~q.ck_s & q.ck_p;
   assign cmd_byte = {q.shift[6:0], q.di_s};
   // Continuous and continuous single-cycle work in the first mode never self-terminate.
   assign continuous = (sequencer_mode_select == 2'h0)
                       & (~single_cycle_enable | continuous_single_cycle);

   // Next state of the whole port.
   always_comb
   begin
      d = q;
      result_clear = 1'b0;
      d.cs_m = bus.select_n;
      d.cs_s = q.cs_m;
      d.ck_m = bus.sclk;
      d.ck_s = q.ck_m;
      d.ck_p = q.ck_s;
      d.di_m = bus.mosi;
      d.di_s = q.di_m;
      d.wr_valid = 1'b0;
      d.cmd_valid = 1'b0;
      d.load = 1'b0;
      if (q.cs_s)
      begin
         // Deselect returns the controller to command reception, whatever was cut short.
         d.phase = acp_pkg::DP_CMD;
         d.bit_cnt = 3'h0;
         d.done_cnt = 2'h0;
         d.out_cnt = 5'h00;
         d.miso = 1'b0;
      end
      else
      begin
         unique case (q.phase)
            acp_pkg::DP_CMD:
            begin
               if (rise)
               begin
                  d.shift = cmd_byte;
                  d.bit_cnt = q.bit_cnt + 3'h1;
                  if (q.bit_cnt == 3'h7)
                  begin
                     if (!cmd_byte[`ACP_START_BIT])
                     begin
                        // A byte without the start bit is not a command; wait for deselect.
                        d.phase = acp_pkg::DP_IGNORE;
                     end
                     else if (!cmd_byte[`ACP_KIND_BIT])
                     begin
                        d.cmd_valid = 1'b1;
                        d.cmd_op = cmd_byte[`ACP_OP_HI:`ACP_OP_LO];
                        d.cmd_rate = cmd_byte[`ACP_RATE_HI:0];
                        d.phase = acp_pkg::DP_IGNORE;
                     end
                     else
                     begin
                        d.addr = cmd_byte[`ACP_ADDR_HI:`ACP_ADDR_LO];
                        if (cmd_byte[`ACP_DIR_BIT])
                        begin
                           // Register data is fetched next cycle, once the address is out.
                           d.phase = acp_pkg::DP_READ;
                           d.load = 1'b1;
                        end
                        else
                        begin
                           d.phase = acp_pkg::DP_WRITE;
                        end
                     end
                  end
               end
            end
            acp_pkg::DP_WRITE:
            begin
               if (rise)
               begin
                  d.shift = cmd_byte;
                  d.bit_cnt = q.bit_cnt + 3'h1;
                  // Nothing is committed until a whole data byte has arrived.
                  if (q.bit_cnt == 3'h7)
                  begin
                     d.wr_valid = 1'b1;
                     d.wr_byte = cmd_byte;
                     d.wr_idx = reg_bytes - 2'h1 - q.done_cnt;
                     d.done_cnt = q.done_cnt + 2'h1;
                     if ((q.done_cnt + 2'h1) >= reg_bytes)
                     begin
                        d.phase = acp_pkg::DP_IGNORE;
                     end
                  end
               end
            end
            acp_pkg::DP_READ:
            begin
               // The data input is not looked at in this phase.
               if (q.load)
               begin
                  d.tx = acp_align(reg_rd_data, reg_bytes);
               end
               if (fall)
               begin
                  // Past the register width zeros follow; read mode lasts until deselect.
                  d.miso = q.tx[23];
                  d.tx = {q.tx[22:0], 1'b0};
                  if (q.out_cnt != 5'h1F)
                  begin
                     d.out_cnt = q.out_cnt + 5'h01;
                  end
                  if ((q.addr == RESULT_ADDR) && (q.out_cnt == 5'(`ACP_RESULT_DONE_BITS - 1)))
                  begin
                     result_clear = 1'b1;
                  end
               end
            end
            acp_pkg::DP_IGNORE:
            begin
               d.phase = acp_pkg::DP_IGNORE;
            end
         endcase
      end
      // A new result arriving in the same cycle as a completed read wins.
      if (result_clear)
      begin
         d.ready_n = 1'b1;
      end
      if (result_update)
      begin
         d.ready_n = 1'b0;
      end
      // Power status follows accepted conversion commands and sequence completion.
      if (q.cmd_valid)
      begin
         unique case (q.cmd_op)
            acp_pkg::OP_POWERDOWN: d.pstat = acp_pkg::acp_pstat_t'(powerdown_target);
            acp_pkg::OP_SEQUENCE: d.pstat = acp_pkg::PS_CONVERT;
            default: d.pstat = q.pstat;
         endcase
      end
      else if (sequence_done && (q.pstat == acp_pkg::PS_CONVERT) && !continuous)
      begin
         d.pstat = acp_pkg::PS_SLEEP;
      end
   end

   // All port state in one register; reset leaves the port deselected and ready high.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         q <= '0;
         q.cs_m <= 1'b1;
         q.cs_s <= 1'b1;
         q.ready_n <= 1'b1;
         q.pstat <= acp_pkg::PS_SLEEP;
      end
      else
      begin
         q <= d;
      end
   end

   // Output released whenever the synchronised select is high.
   assign bus.miso = q.miso;
   assign bus.miso_oe_n = q.cs_s;
   assign bus.result_ready_n = q.ready_n;
   assign reg_addr = q.addr;
   assign reg_wr_valid = q.wr_valid;
   assign reg_wr_index = q.wr_idx;
   assign reg_wr_byte = q.wr_byte;
   assign cmd_valid = q.cmd_valid;
   assign cmd_operation = q.cmd_op;
   assign cmd_rate = q.cmd_rate;
   // Calibration kind is taken from the live setting at the command pulse.
   assign calibration_start = q.cmd_valid & (q.cmd_op == acp_pkg::OP_CALIBRATE);
   assign calibration_kind = calibration_select;
   assign power_status = q.pstat;

endmodule : acp_device
`default_nettype wire

// [rtl/acp_host.sv]
// Host end of the converter serial command port: frames one transaction per request.
`timescale 1ns/1ps
`default_nettype none
`include "acp_defines.svh"
module acp_host #(
   parameter int unsigned HALF_CYC = `ACP_SCLK_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   acp_if.host bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_reg,
   input wire logic [1:0] req_op,
   input wire logic [3:0] req_rate,
   input wire logic [4:0] req_addr,
   input wire logic req_read,
   input wire logic [23:0] req_wdata,
   input wire logic [4:0] req_len,
   output logic rsp_valid,
   output logic [23:0] rsp_data,
   output logic result_pending
);

   typedef struct packed {
      logic ms_m;
      logic ms_s;
      logic rr_m;
      logic rr_s;
      acp_pkg::acp_hphase_t phase;
      logic [7:0] div;
      logic [5:0] cnt;
      logic [5:0] total;
      logic [31:0] tx;
      logic [23:0] rx;
      logic sclk;
      logic sel_n;
      logic mosi;
      logic rsp_valid;
   } acp_host_state_t;

   acp_host_state_t q;
   acp_host_state_t d;
   logic half_done;
   logic [7:0] cmd;

   assign half_done = (q.div == 8'(HALF_CYC - 1));
   // Conversion commands carry operation and rate; mode exit is an OP_POWERDOWN command.
   assign cmd = req_reg ? acp_pkg::acp_reg_cmd(req_addr, req_read)
                        : acp_pkg::acp_conv_cmd(req_op, req_rate);
   assign req_ready = (q.phase == acp_pkg::HP_IDLE);

   // Clock divider and frame sequencing; the serial clock idles low.
   always_comb
   begin
      d = q;
      d.ms_m = bus.miso;
      d.ms_s = q.ms_m;
      d.rr_m = bus.result_ready_n;
      d.rr_s = q.rr_m;
      d.rsp_valid = 1'b0;
      d.div = half_done ? 8'h00 : q.div + 8'h01;
      unique case (q.phase)
         acp_pkg::HP_IDLE:
         begin
            d.div = 8'h00;
            if (req_valid)
            begin
               // A result read should ask for at least 23 bits to finish it.
               d.tx = {cmd, req_wdata};
               d.total = 6'(`ACP_CMD_BITS) + {1'b0, req_len};
               d.cnt = 6'h00;
               d.sel_n = 1'b0;
               d.mosi = cmd[7];
               d.phase = acp_pkg::HP_LOW;
            end
         end
         acp_pkg::HP_LOW:
         begin
            if (half_done)
            begin
               // Capture on the rising edge, half a period after the device launched.
               d.sclk = 1'b1;
               d.rx = {q.rx[22:0], q.ms_s};
               d.phase = acp_pkg::HP_HIGH;
            end
         end
         acp_pkg::HP_HIGH:
         begin
            if (half_done)
            begin
               d.sclk = 1'b0;
               d.cnt = q.cnt + 6'h01;
               d.tx = {q.tx[30:0], 1'b0};
               d.mosi = q.tx[30];
               d.phase = ((q.cnt + 6'h01) == q.total) ? acp_pkg::HP_END : acp_pkg::HP_LOW;
            end
         end
         acp_pkg::HP_END:
         begin
            // Select stays low for the whole access and rises only after the last clock.
            if (half_done)
            begin
               d.sel_n = 1'b1;
               d.mosi = 1'b0;
               d.rsp_valid = 1'b1;
               d.phase = acp_pkg::HP_GAP;
            end
         end
         acp_pkg::HP_GAP:
         begin
            if (half_done)
            begin
               d.phase = acp_pkg::HP_IDLE;
            end
         end
         default:
         begin
            d.phase = acp_pkg::HP_IDLE;
         end
      endcase
   end

   // All host state in one register.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         q <= '0;
         q.sel_n <= 1'b1;
         q.rr_m <= 1'b1;
         q.rr_s <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign bus.select_n = q.sel_n;
   assign bus.sclk = q.sclk;
   assign bus.mosi = q.mosi;
   assign rsp_valid = q.rsp_valid;
   assign rsp_data = q.rx;
   assign result_pending = ~q.rr_s;

endmodule : acp_host
`default_nettype wire

// [tb/acp_port_properties.sv]
// Pin-level checks on the serial link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module acp_port_properties (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire logic result_ready_n
);
   logic sclk_q;
   logic [5:0] rises_q;
   // Counts clock rises per frame, so the command bit and frame length can be judged.
   always_ff @(posedge sys_clk)
   begin
      sclk_q <= sclk;
      if (reset || select_n)
         rises_q <= 6'h00;
      else if (sclk && !sclk_q)
         rises_q <= rises_q + 6'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_OE_OFF: assert property (select_n [*5] |-> miso_oe_n)
      else $error("data output driven while deselected");
   AST_OE_ON: assert property (!select_n [*5] |-> !miso_oe_n)
      else $error("data output not driven while selected");
   AST_SCLK_IDLE: assert property (select_n |-> !sclk)
      else $error("serial clock active outside a frame");
   AST_MOSI_HOLD: assert property (!select_n && sclk && $past(sclk) |-> $stable(mosi))
      else $error("host data moved while clock high");
   AST_MISO_HOLD: assert property (!miso_oe_n && !$past(miso_oe_n) && sclk && $past(sclk)
      |-> $stable(miso))
      else $error("device data moved while clock high");
   AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("clock high phase is not eight cycles");
   AST_START_BIT: assert property (sclk && !sclk_q && rises_q == 6'h00 |-> mosi)
      else $error("command byte does not start with a one");
   AST_FRAME_LEN: assert property ($rose(select_n) |-> rises_q >= 6'h08 && rises_q <= 6'h20)
      else $error("frame clock count out of range");
   AST_GAP: assert property ($rose(select_n) |-> select_n [*8])
      else $error("select gap shorter than a half period");
   AST_READY_IN_FRAME: assert property ($rose(result_ready_n) |-> !select_n)
      else $error("ready released outside a result read");
endmodule : acp_port_properties
`default_nettype wire

// [tb/adc_spi_command_port_tb.sv]
// Self-checking bench joining the host and device ends of the command port.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_command_port_tb;
   localparam logic [4:0] RES_ADDR = 5'h08;
   logic sys_clk, reset, req_valid, req_ready, req_reg, req_read, rsp_valid, result_pending;
   logic reg_wr_valid, cmd_valid, calibration_start, single_cycle_enable;
   logic continuous_single_cycle, result_update, sequence_done;
   logic [1:0] req_op, reg_bytes, reg_wr_index, cmd_operation, calibration_select, ps;
   logic [1:0] calibration_kind, powerdown_target, sequencer_mode_select, power_status;
   logic [3:0] req_rate, cmd_rate;
   logic [4:0] req_addr, req_len, reg_addr;
   logic [7:0] reg_wr_byte;
   logic [23:0] req_wdata, rsp_data, reg_rd_data, rsp;
   logic [23:0] mem [32];
   logic [23:0] exp_mem [32];
   logic [31:0] lfsr_q;
   int fails, num_checks, cmd_count, cal_count, n, c;
   acp_if bus_if ();
   acp_device #(.RESULT_ADDR(RES_ADDR)) acp_device_i (.sys_clk(sys_clk), .reset(reset),
      .bus(bus_if.device), .reg_addr(reg_addr), .reg_bytes(reg_bytes),
      .reg_rd_data(reg_rd_data), .reg_wr_valid(reg_wr_valid), .reg_wr_index(reg_wr_index),
      .reg_wr_byte(reg_wr_byte), .cmd_valid(cmd_valid), .cmd_operation(cmd_operation),
      .cmd_rate(cmd_rate), .calibration_start(calibration_start),
      .calibration_select(calibration_select), .calibration_kind(calibration_kind),
      .powerdown_target(powerdown_target), .sequencer_mode_select(sequencer_mode_select),
      .single_cycle_enable(single_cycle_enable), .continuous_single_cycle(continuous_single_cycle),
      .result_update(result_update), .sequence_done(sequence_done), .power_status(power_status));
   acp_host acp_host_i (.sys_clk(sys_clk), .reset(reset), .bus(bus_if.host),
      .req_valid(req_valid), .req_ready(req_ready), .req_reg(req_reg), .req_op(req_op),
      .req_rate(req_rate), .req_addr(req_addr), .req_read(req_read), .req_wdata(req_wdata),
      .req_len(req_len), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .result_pending(result_pending));
   acp_port_properties acp_port_properties_i (.sys_clk(sys_clk), .reset(reset),
      .select_n(bus_if.select_n), .sclk(bus_if.sclk), .mosi(bus_if.mosi), .miso(bus_if.miso),
      .miso_oe_n(bus_if.miso_oe_n), .result_ready_n(bus_if.result_ready_n));
   // Register file behind the device; widths of one to three bytes by address.
   assign reg_rd_data = mem[reg_addr];
   assign reg_bytes = 2'(reg_addr % 5'h03) + 2'h1;
   always @(posedge sys_clk)
   begin
      if (reg_wr_valid === 1'b1)
         mem[reg_addr][8 * reg_wr_index +: 8] <= reg_wr_byte;
      if (cmd_valid === 1'b1)
         cmd_count++;
      if (calibration_start === 1'b1)
         cal_count++;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // One host request; fields stay put until the next frame so callers can model it.
   task automatic frame(input logic rg, input logic [1:0] op, input logic [4:0] a,
      input logic rd, input logic [4:0] len);
      int k;
      check("host idle", 24'h1, {23'h0, req_ready});
      lfsr_q = next_rand(lfsr_q);
      req_reg = rg;
      req_op = op;
      req_rate = lfsr_q[3:0];
      req_addr = a;
      req_read = rd;
      req_wdata = lfsr_q[31:8];
      req_len = len;
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      for (k = 0; k < 2000 && rsp_valid !== 1'b1; k++)
      begin
         @(posedge sys_clk);
         #1;
      end
      rsp = rsp_data;
      check("response", 24'h1, {23'h0, rsp_valid});
      repeat (12) @(posedge sys_clk);
      #1;
   endtask : frame
   task automatic reg_write(input logic [4:0] a, input logic [4:0] len);
      int w;
      w = a % 3 + 1;
      frame(1'b1, 2'b00, a, 1'b0, len);
      for (int k = 0; k < w && k < len / 8; k++)
         exp_mem[a][(w - 1 - k) * 8 +: 8] = req_wdata[23 - 8 * k -: 8];
      check("register", exp_mem[a], mem[a]);
   endtask : reg_write
   // Reads drive random noise on the data input; the register must not move.
   task automatic reg_read(input logic [4:0] a, input logic [4:0] len);
      logic [23:0] mask;
      mask = 24'hFFFFFF >> (24 - len);
      frame(1'b1, 2'b00, a, 1'b1, len);
      check("read data", (exp_mem[a] << (8 * (2 - a % 3))) >> (24 - len), rsp & mask);
      check("after read", exp_mem[a], mem[a]);
   endtask : reg_read
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Hang guard at thirty thousand cycles, about four times the expected run.
   initial
   begin
      #300000;
      fails++;
      $display("mismatch watchdog expected finish seen timeout");
      conclude();
   end
   initial
   begin
      {reset, req_valid, req_reg, req_read, result_update, sequence_done} = 6'h20;
      {single_cycle_enable, continuous_single_cycle, req_op, req_rate} = 8'h00;
      {calibration_select, powerdown_target, sequencer_mode_select} = 6'h04;
      {req_addr, req_len, req_wdata} = 34'h0;
      {fails, num_checks, cmd_count, cal_count} = '0;
      lfsr_q = 32'h4DF96FD2;
      ps = 2'b01;
      for (int i = 0; i < 32; i++)
      begin
         lfsr_q = next_rand(lfsr_q);
         mem[i] = lfsr_q[23:0];
         exp_mem[i] = lfsr_q[23:0];
      end
      repeat (12) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      // Reset leaves the port asleep, ready high and the data output released.
      check("reset status", 24'h1, {22'h0, power_status});
      check("reset ready", 24'h1, {23'h0, bus_if.result_ready_n});
      check("reset release", 24'h1, {23'h0, bus_if.miso_oe_n});
      // Full writes of each width, then 24-bit reads, past the width for the one- and two-byte registers.
      for (int a = 1; a < 4; a++)
      begin
         reg_write(5'(a), 5'(8 * (a % 3 + 1)));
         reg_read(5'(a), 5'h18);
      end
      reg_write(5'h02, 5'h08);
      reg_write(5'h02, 5'h07);
      reg_write(5'h02, 5'h11);
      reg_write(5'h03, 5'h18);
      reg_read(5'h02, 5'h05);
      // Every operation code with a random rate and settings.
      for (int op = 0; op < 4; op++)
      begin
         lfsr_q = next_rand(lfsr_q);
         powerdown_target = lfsr_q[0] ? 2'b10 : 2'b01;
         calibration_select = lfsr_q[2:1];
         n = cmd_count;
         c = cal_count;
         frame(1'b0, 2'(op), 5'h00, 1'b0, 5'h00);
         ps = (op == 1) ? powerdown_target : (op == 3) ? 2'b00 : ps;
         check("commands", 24'(n + 1), 24'(cmd_count));
         check("operation", 24'(op), {22'h0, cmd_operation});
         check("rate", {20'h0, req_rate}, {20'h0, cmd_rate});
         check("calibrations", 24'(c + (op == 2)), 24'(cal_count));
         check("cal kind", {22'h0, calibration_select}, {22'h0, calibration_kind});
         check("power status", {22'h0, ps}, {22'h0, power_status});
      end
      // Sequencer end: only the continuous first-mode cases keep converting.
      for (int i = 0; i < 5; i++)
      begin
         sequencer_mode_select = 2'(i > 2 ? i - 2 : 0);
         single_cycle_enable = (i != 0);
         continuous_single_cycle = (i == 1);
         frame(1'b0, 2'b11, 5'h00, 1'b0, 5'h00);
         check("running", 24'h0, {22'h0, power_status});
         sequence_done = 1'b1;
         @(posedge sys_clk);
         #1;
         sequence_done = 1'b0;
         repeat (3) @(posedge sys_clk);
         #1;
         check("after sequence", (i < 2) ? 24'h0 : 24'h1, {22'h0, power_status});
      end
      // Result path: a short read leaves the result pending, a full one clears it.
      result_update = 1'b1;
      @(posedge sys_clk);
      #1;
      result_update = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      check("ready", 24'h0, {23'h0, bus_if.result_ready_n});
      check("pending", 24'h1, {23'h0, result_pending});
      reg_read(RES_ADDR, 5'h15);
      check("ready short", 24'h0, {23'h0, bus_if.result_ready_n});
      reg_read(RES_ADDR, 5'h17);
      check("ready full", 24'h1, {23'h0, bus_if.result_ready_n});
      conclude();
   end
endmodule : adc_spi_command_port_tb
`default_nettype wire
